/* hdl/low_power_mode_controller.sv */
// low power mode controller: debug, wait and stop mode sequencing
// assumes one 200 MHz clock, an AHB-Lite master, and a core that
// pulses its instruction strobes for one cycle while running
// Notes on behaviour
// - debug mode entered by strap at reset, force command, instruction or breakpoints
// - in debug mode the core is suspended; only a trace command opens its clock, for one cycle
// - memory, status memory, debug register and force commands accepted in run
// - core register, trace and resume only accepted in debug mode
// - wait stops the core clock and clears the interrupt mask
// - an interrupt in wait resumes the core through interrupt stacking
// - wait, or stop3 with debug permit, accept only force and status memory; status memory reports error
// - force command during wait enters debug mode
// - stop with stop permit 0 gives an illegal opcode reset
// - every stop mode halts bus and core clocks
// - stop with debug permit 1 enters stop3 keeping debug clock and regulator
// - both brownout bits 1 without debug permit give stop3 with regulator on
// - else power down select picks stop3, stop2 or stop1
// - stop3 keeps all state, memory and pin states
// - stop3 leaves on reset pin via reset vector, or on wake interrupts
// - with debug permit, force command wakes stop into debug mode
// - entering stop2 latches all pin controls
// - in stop1 and stop2 the wake pin low or periodic wake wakes
// - stop1 or stop2 wake acts as power-on reset with brownout hold
// - stop2 wake sets partial flag; flag and latches held until acknowledge
// - stop1 sends pins to reset state; its wake sets full flag until acknowledge
// - reset release with strap high runs from the reset vector
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`include "lpm_map.svh"
module low_power_mode_controller #(
    parameter int ADDR_W = 12
) (
    input  wire logic                 clock_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 hsel_i,
    input  wire logic [ADDR_W-1:0]    haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    output logic [31:0]               hrdata_o,
    input  wire logic                 wait_instr_i,
    input  wire logic                 stop_instr_i,
    input  wire logic                 enter_debug_instr_i,
    input  wire logic                 debug_ctrl_break_i,
    input  wire logic                 debug_unit_break_i,
    input  wire logic                 force_debug_reset_i,
    input  wire logic                 irq_pending_i,
    input  wire lpm_pkg::wake_src_type wake_irq_i,
    input  wire lpm_pkg::dbg_req_type dbg_req_i,
    output lpm_pkg::dbg_resp_type     dbg_resp_o,
    input  wire logic                 debug_mode_select_pin_i,
    input  wire logic                 wake_pin_i,
    input  wire logic                 reset_pin_n_i,
    input  wire logic                 supply_low_i,
    output lpm_pkg::mode_type         mode_o,
    output logic                      cpu_clock_en_o,
    output logic                      bus_clock_en_o,
    output logic                      debug_clock_en_o,
    output logic                      regulator_full_o,
    output logic                      core_reset_o,
    output logic                      illegal_opcode_reset_o,
    output logic                      reset_vector_fetch_o,
    output logic                      irq_vector_take_o,
    output logic                      clear_imask_o,
    output logic                      pin_latch_o,
    output logic                      pins_to_reset_o,
    output logic                      wake_pin_input_mode_o
);
    localparam int RST_HOLD = `LPM_RST_HOLD_CYC;

    if (ADDR_W < 4) begin : g_chk
        $error("ADDR_W too small for the register map");
    end

    // pins: two flops each, only the second stage is read
    logic [3:0] pin_raw;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    assign pin_raw = {supply_low_i, reset_pin_n_i, wake_pin_i, debug_mode_select_pin_i};
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge clock_i) begin
            sync1_r[i] <= pin_raw[i];
            sync2_r[i] <= sync1_r[i];
        end
    end
    logic dbgsel_s;
    logic wake_pin_s;
    logic reset_pin_s;
    logic supply_low_s;
    assign dbgsel_s     = sync2_r[0];
    assign wake_pin_s   = sync2_r[1];
    assign reset_pin_s  = sync2_r[2];
    assign supply_low_s = sync2_r[3];

    lpm_pkg::mode_type mode_r;
    lpm_pkg::mode_type mode_nxt;
    logic [`LPM_CTRL_W-1:0] ctrl_r;
    logic partial_down_wake_flag_r;
    logic pdf_r;
    logic latch_r;
    logic por_like_r;
    logic stop_dbg_r;
    logic stop_reg_r;
    logic step_r;
    logic [1:0] rst_cnt_r;
    logic ack_wr;

    // stop mode choice from the control bits
    lpm_pkg::mode_type stop_sel;
    always_comb begin
        if (ctrl_r[`LPM_CTRL_DEBUG_PERMIT]) begin
            stop_sel = lpm_pkg::MODE_STOP3;
        end else if (ctrl_r[`LPM_CTRL_BO_ON] && ctrl_r[`LPM_CTRL_BO_SLEEP]) begin
            stop_sel = lpm_pkg::MODE_STOP3;
        end else if (!ctrl_r[`LPM_CTRL_PD_SEL]) begin
            stop_sel = lpm_pkg::MODE_STOP3;
        end else if (ctrl_r[`LPM_CTRL_PPD_SEL]) begin
            stop_sel = lpm_pkg::MODE_STOP2;
        end else begin
            stop_sel = lpm_pkg::MODE_STOP1;
        end
    end

    // debug command gating per mode
    logic cmd_ok;
    logic force_cmd;
    logic resume_cmd;
    logic trace_cmd;
    logic low_cmd;
    logic dbg_live;
    assign low_cmd  = (dbg_req_i.cmd == lpm_pkg::CMD_FORCE) ||
                      (dbg_req_i.cmd == lpm_pkg::CMD_MEM_STATUS);
    // stopped debug logic has no clock unless stop3 kept it
    assign dbg_live = (mode_r == lpm_pkg::MODE_WAIT) ||
                      ((mode_r == lpm_pkg::MODE_STOP3) && stop_dbg_r);
    always_comb begin
        case (mode_r)
            lpm_pkg::MODE_RUN: begin
                cmd_ok = dbg_req_i.cmd <= lpm_pkg::CMD_FORCE;
            end
            lpm_pkg::MODE_DEBUG: begin
                cmd_ok = 1'b1;
            end
            default: begin
                cmd_ok = dbg_live && low_cmd;
            end
        endcase
    end
    assign force_cmd  = dbg_req_i.valid && cmd_ok && (dbg_req_i.cmd == lpm_pkg::CMD_FORCE);
    assign resume_cmd = dbg_req_i.valid && cmd_ok && (dbg_req_i.cmd == lpm_pkg::CMD_RESUME);
    assign trace_cmd  = dbg_req_i.valid && cmd_ok && (dbg_req_i.cmd == lpm_pkg::CMD_TRACE);

    logic any_wake3;
    assign any_wake3 = |wake_irq_i;

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            lpm_pkg::MODE_RST: begin
                // brownout holds reset while supply is low
                if (rst_cnt_r == 2'h0 && !supply_low_s) begin
                    if (por_like_r && !dbgsel_s) begin
                        mode_nxt = lpm_pkg::MODE_DEBUG;
                    end else begin
                        mode_nxt = lpm_pkg::MODE_RUN;
                    end
                end
            end
            lpm_pkg::MODE_RUN: begin
                if (force_cmd || enter_debug_instr_i ||
                    debug_ctrl_break_i || debug_unit_break_i) begin
                    mode_nxt = lpm_pkg::MODE_DEBUG;
                end else if (stop_instr_i) begin
                    if (!ctrl_r[`LPM_CTRL_STOP_PERMIT]) begin
                        mode_nxt = lpm_pkg::MODE_RST;
                    end else begin
                        mode_nxt = stop_sel;
                    end
                end else if (wait_instr_i) begin
                    mode_nxt = lpm_pkg::MODE_WAIT;
                end
            end
            lpm_pkg::MODE_DEBUG: begin
                if (resume_cmd) begin
                    mode_nxt = lpm_pkg::MODE_RUN;
                end
            end
            lpm_pkg::MODE_WAIT: begin
                if (force_cmd) begin
                    mode_nxt = lpm_pkg::MODE_DEBUG;
                end else if (irq_pending_i) begin
                    mode_nxt = lpm_pkg::MODE_RUN;
                end
            end
            lpm_pkg::MODE_STOP3: begin
                if (!reset_pin_s) begin
                    mode_nxt = lpm_pkg::MODE_RST;
                end else if (force_cmd) begin
                    mode_nxt = lpm_pkg::MODE_DEBUG;
                end else if (any_wake3) begin
                    mode_nxt = lpm_pkg::MODE_RUN;
                end
            end
            lpm_pkg::MODE_STOP2, lpm_pkg::MODE_STOP1: begin
                if (!wake_pin_s || wake_irq_i.periodic) begin
                    mode_nxt = lpm_pkg::MODE_RST;
                end
            end
            default: begin
                mode_nxt = lpm_pkg::MODE_RST;
            end
        endcase
        // a forced debug reset restarts the sequence from any mode but reset
        if (force_debug_reset_i && mode_r != lpm_pkg::MODE_RST) begin
            mode_nxt = lpm_pkg::MODE_RST;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            mode_r <= lpm_pkg::MODE_RST;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    logic deep_wake;
    logic enter_rst;
    assign deep_wake = ((mode_r == lpm_pkg::MODE_STOP2) || (mode_r == lpm_pkg::MODE_STOP1)) &&
                       (mode_nxt == lpm_pkg::MODE_RST);
    assign enter_rst = (mode_r != lpm_pkg::MODE_RST) && (mode_nxt == lpm_pkg::MODE_RST);

    // reset hold counter and kind of reset for the strap check
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            rst_cnt_r  <= 2'(RST_HOLD);
            por_like_r <= 1'b1;
        end else if (enter_rst) begin
            rst_cnt_r  <= 2'(RST_HOLD);
            por_like_r <= deep_wake || force_debug_reset_i;
        end else if (mode_r == lpm_pkg::MODE_RST && rst_cnt_r != 2'h0) begin
            rst_cnt_r <= rst_cnt_r - 2'h1;
        end
    end

    // a forced debug reset outside the sequencer arrives as a request
    // held until the controller is back in reset
    logic fdr_pend_r;
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            fdr_pend_r <= 1'b0;
        end else if (force_debug_reset_i) begin
            fdr_pend_r <= 1'b1;
        end else if (mode_r == lpm_pkg::MODE_RST) begin
            fdr_pend_r <= 1'b0;
        end
    end

    // stop entry flavour latched for the duration of the stop
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            stop_dbg_r <= 1'b0;
            stop_reg_r <= 1'b0;
        end else if (mode_r == lpm_pkg::MODE_RUN && mode_nxt == stop_sel) begin
            stop_dbg_r <= ctrl_r[`LPM_CTRL_DEBUG_PERMIT];
            stop_reg_r <= ctrl_r[`LPM_CTRL_DEBUG_PERMIT] ||
                          (ctrl_r[`LPM_CTRL_BO_ON] && ctrl_r[`LPM_CTRL_BO_SLEEP]);
        end
    end

    // single trace step opens the core clock for one cycle
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            step_r <= 1'b0;
        end else begin
            step_r <= trace_cmd && (mode_r == lpm_pkg::MODE_DEBUG);
        end
    end

    // one cycle event pulses towards the core
    logic ill_r;
    logic rvec_r;
    logic ivec_r;
    logic imask_r;
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            ill_r   <= 1'b0;
            rvec_r  <= 1'b0;
            ivec_r  <= 1'b0;
            imask_r <= 1'b0;
        end else begin
            ill_r   <= mode_r == lpm_pkg::MODE_RUN && stop_instr_i &&
                       mode_nxt == lpm_pkg::MODE_RST && !ctrl_r[`LPM_CTRL_STOP_PERMIT];
            rvec_r  <= mode_r == lpm_pkg::MODE_RST &&
                       mode_nxt == lpm_pkg::MODE_RUN;
            ivec_r  <= (mode_r == lpm_pkg::MODE_WAIT || mode_r == lpm_pkg::MODE_STOP3) &&
                       mode_nxt == lpm_pkg::MODE_RUN;
            imask_r <= mode_r == lpm_pkg::MODE_RUN &&
                       mode_nxt == lpm_pkg::MODE_WAIT;
        end
    end

    // recovery flags and pin latch: a wake, or for the latch stop2, in the acknowledge cycle wins
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            partial_down_wake_flag_r  <= 1'b0;
            pdf_r   <= 1'b0;
            latch_r <= 1'b0;
        end else begin
            if (deep_wake && mode_r == lpm_pkg::MODE_STOP2) begin
                partial_down_wake_flag_r <= 1'b1;
            end else if (ack_wr) begin
                partial_down_wake_flag_r <= 1'b0;
            end
            if (deep_wake && mode_r == lpm_pkg::MODE_STOP1) begin
                pdf_r <= 1'b1;
            end else if (ack_wr) begin
                pdf_r <= 1'b0;
            end
            if (mode_nxt == lpm_pkg::MODE_STOP2) begin
                latch_r <= 1'b1;
            end else if (ack_wr) begin
                latch_r <= 1'b0;
            end
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    logic            dph_wr_r;
    logic [ADDR_W-1:0] dph_addr_r;
    logic            aph;
    assign aph = hsel_i && hready_i && htrans_i[1];
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            dph_wr_r   <= 1'b0;
            dph_addr_r <= '0;
        end else if (hready_i) begin
            dph_wr_r   <= aph && hwrite_i;
            dph_addr_r <= haddr_i;
        end
    end
    logic wr_ctrl;
    assign wr_ctrl = dph_wr_r && dph_addr_r[3:0] == 4'(`LPM_CTRL_OFS);
    assign ack_wr  = dph_wr_r && dph_addr_r[3:0] == 4'(`LPM_STAT_OFS) &&
                     hwdata_i[`LPM_STAT_ACK];

    // control bits return to defaults on a stop2 or stop1 wake
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            ctrl_r <= `LPM_CTRL_RESET;
        end else if (deep_wake) begin
            ctrl_r <= `LPM_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= hwdata_i[`LPM_CTRL_W-1:0];
        end
    end

    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (haddr_i[3:0] == 4'(`LPM_CTRL_OFS)) begin
            rd_nxt[`LPM_CTRL_W-1:0] = ctrl_r;
        end else if (haddr_i[3:0] == 4'(`LPM_STAT_OFS)) begin
            rd_nxt[`LPM_STAT_PARTIAL_DOWN_WAKE_FLAG]  = partial_down_wake_flag_r;
            rd_nxt[`LPM_STAT_PDF]   = pdf_r;
            rd_nxt[`LPM_STAT_LATCH] = latch_r;
            rd_nxt[`LPM_STAT_MODE_LSB +: 7] = mode_r;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (aph && !hwrite_i) begin
            hrdata_o <= rd_nxt;
        end
    end
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // debug command answer, one cycle after the request
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            dbg_resp_o <= '0;
        end else begin
            dbg_resp_o.accept   <= dbg_req_i.valid && cmd_ok;
            dbg_resp_o.stop_err <= dbg_req_i.valid && cmd_ok && dbg_live &&
                                   dbg_req_i.cmd == lpm_pkg::CMD_MEM_STATUS;
        end
    end

    logic in_stop;
    assign in_stop = mode_r == lpm_pkg::MODE_STOP3 || mode_r == lpm_pkg::MODE_STOP2 ||
                     mode_r == lpm_pkg::MODE_STOP1;
    assign mode_o                 = mode_r;
    assign cpu_clock_en_o         = mode_r == lpm_pkg::MODE_RUN || step_r;
    assign bus_clock_en_o         = !in_stop;
    assign debug_clock_en_o       = !in_stop || stop_dbg_r;
    assign regulator_full_o       = !in_stop || stop_reg_r;
    // stop3 gates clocks and may lower the regulator but resets nothing, so all state is kept as is
    assign core_reset_o           = mode_r == lpm_pkg::MODE_RST || fdr_pend_r;
    assign illegal_opcode_reset_o = ill_r;
    assign reset_vector_fetch_o   = rvec_r;
    assign irq_vector_take_o      = ivec_r;
    assign clear_imask_o          = imask_r;
    assign pin_latch_o            = latch_r;
    assign pins_to_reset_o        = mode_r == lpm_pkg::MODE_STOP1;
    assign wake_pin_input_mode_o  = mode_r == lpm_pkg::MODE_STOP2 ||
                                    mode_r == lpm_pkg::MODE_STOP1;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence run_stop_s;
        mode_r == lpm_pkg::MODE_RUN && stop_instr_i && !force_cmd &&
        !enter_debug_instr_i && !debug_ctrl_break_i && !debug_unit_break_i &&
        !force_debug_reset_i;
    endsequence
    sequence wait_irq_s;
        mode_r == lpm_pkg::MODE_WAIT && irq_pending_i && !force_cmd && !force_debug_reset_i;
    endsequence

    illegal_stop_a: assert property (
        run_stop_s ##0 !ctrl_r[`LPM_CTRL_STOP_PERMIT] |=>
        mode_r == lpm_pkg::MODE_RST && illegal_opcode_reset_o)
        else $error("illegal stop did not reset");
    stop_debug_a: assert property (
        run_stop_s ##0 ctrl_r[`LPM_CTRL_STOP_PERMIT] && ctrl_r[`LPM_CTRL_DEBUG_PERMIT] |=>
        mode_r == lpm_pkg::MODE_STOP3 && debug_clock_en_o && regulator_full_o)
        else $error("debug permitted stop not stop3");
    stop_select_a: assert property (
        run_stop_s ##0 ctrl_r[`LPM_CTRL_STOP_PERMIT] && !ctrl_r[`LPM_CTRL_DEBUG_PERMIT] &&
        !(ctrl_r[`LPM_CTRL_BO_ON] && ctrl_r[`LPM_CTRL_BO_SLEEP]) &&
        ctrl_r[`LPM_CTRL_PD_SEL] |=>
        mode_r == (ctrl_r[`LPM_CTRL_PPD_SEL] ? lpm_pkg::MODE_STOP2 : lpm_pkg::MODE_STOP1))
        else $error("wrong deep stop chosen");
    stop_clocks_a: assert property (
        in_stop |-> !bus_clock_en_o && !cpu_clock_en_o)
        else $error("clocks run in stop");
    wait_entry_a: assert property (
        mode_r == lpm_pkg::MODE_RUN ##1 mode_r == lpm_pkg::MODE_WAIT |->
        clear_imask_o && !cpu_clock_en_o && bus_clock_en_o)
        else $error("wait entry wrong");
    wait_wake_a: assert property (
        wait_irq_s |=> mode_r == lpm_pkg::MODE_RUN ##0 irq_vector_take_o)
        else $error("interrupt did not end wait");
    stop_cmd_a: assert property (
        (mode_r == lpm_pkg::MODE_WAIT || in_stop) && dbg_req_i.valid && !low_cmd |=>
        !dbg_resp_o.accept)
        else $error("command accepted in low power");
    force_wake_a: assert property (
        force_cmd && (mode_r == lpm_pkg::MODE_WAIT || mode_r == lpm_pkg::MODE_STOP3) &&
        reset_pin_s && !force_debug_reset_i |=> mode_r == lpm_pkg::MODE_DEBUG)
        else $error("force command did not enter debug");
    active_cmd_a: assert property (
        mode_r != lpm_pkg::MODE_DEBUG && dbg_req_i.valid &&
        dbg_req_i.cmd >= lpm_pkg::CMD_CPU_REG |=> !dbg_resp_o.accept)
        else $error("active command outside debug");
    flag_hold_a: assert property (
        partial_down_wake_flag_r && latch_r && !ack_wr |=> partial_down_wake_flag_r && latch_r)
        else $error("partial flag dropped without ack");
    deep_wake_a: assert property (
        mode_r == lpm_pkg::MODE_STOP1 && !wake_pin_s |=>
        mode_r == lpm_pkg::MODE_RST && pdf_r && ctrl_r == `LPM_CTRL_RESET)
        else $error("stop1 wake not reset-like");
endmodule

/* hdl/lpm_map.svh */
// register offsets, field positions, reset values and timing counts
// assumes the includer needs nothing else; definitions only
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
`define LPM_CTRL_OFS     12'h000
`define LPM_STAT_OFS     12'h004
`define LPM_CTRL_STOP_PERMIT   0
`define LPM_CTRL_DEBUG_PERMIT  1
`define LPM_CTRL_BO_ON         2
`define LPM_CTRL_BO_SLEEP      3
`define LPM_CTRL_PD_SEL        4
`define LPM_CTRL_PPD_SEL       5
`define LPM_CTRL_W             6
`define LPM_CTRL_RESET   6'h00
`define LPM_STAT_PARTIAL_DOWN_WAKE_FLAG          0
`define LPM_STAT_PDF           1
`define LPM_STAT_ACK           2
`define LPM_STAT_LATCH         3
`define LPM_STAT_MODE_LSB      8
`define LPM_CLK_NS             5
`define LPM_RST_HOLD_NS        10
`define LPM_RST_HOLD_CYC ((`LPM_RST_HOLD_NS + `LPM_CLK_NS - 1) / `LPM_CLK_NS)
`endif

/* hdl/lpm_pkg.sv */
// types shared by the mode controller and its surroundings
// assumes no other package
package lpm_pkg;
    typedef enum logic [6:0] {
        MODE_RST   = 7'h01,
        MODE_RUN   = 7'h02,
        MODE_DEBUG = 7'h04,
        MODE_WAIT  = 7'h08,
        MODE_STOP3 = 7'h10,
        MODE_STOP2 = 7'h20,
        MODE_STOP1 = 7'h40
    } mode_type;
    typedef enum logic [2:0] {
        CMD_MEM        = 3'h0,
        CMD_MEM_STATUS = 3'h1,
        CMD_DBG_REG    = 3'h2,
        CMD_FORCE      = 3'h3,
        CMD_CPU_REG    = 3'h4,
        CMD_TRACE      = 3'h5,
        CMD_RESUME     = 3'h6
    } dbg_cmd_type;
    typedef struct packed {
        logic        valid;
        dbg_cmd_type cmd;
    } dbg_req_type;
    typedef struct packed {
        logic accept;
        logic stop_err;
    } dbg_resp_type;
    typedef struct packed {
        logic periodic;
        logic brownout;
        logic converter;
        logic ext_irq;
        logic key;
    } wake_src_type;
endpackage

/* tb/debug_host_model.sv */
// single-wire debug host model: one command per call, answer read back
// assumes the block answers at the edge that takes a request, read back 1 ns later
`timescale 1ns/100ps
module debug_host_model (
    input  wire logic                  clk_i,
    input  wire lpm_pkg::dbg_resp_type resp_i,
    output lpm_pkg::dbg_req_type       req_o
);
    initial req_o = '0;
    task automatic send(input lpm_pkg::dbg_cmd_type c,
                        output lpm_pkg::dbg_resp_type r);
        @(posedge clk_i);
        req_o <= '{1'b1, c};
        @(posedge clk_i);
        // idle field flips so nothing leans on a stale command
        req_o <= '{1'b0, lpm_pkg::dbg_cmd_type'(~c)};
        #1 r = resp_i;
    endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the low power mode controller
// assumes zero-wait bus answers are still awaited; one 200 MHz clock
`timescale 1ns/100ps
`include "lpm_map.svh"
module testbench;
    logic                  clock_i = 1'b0;
    logic                  reset_n_i = 1'b0;
    logic [1:0]            htrans = 2'h0;
    logic                  hwrite = 1'b0;
    logic [11:0]           haddr = 12'h000;
    logic [31:0]           hwdata = 32'h0000_0000;
    logic [31:0]           hrdata;
    logic [31:0]           r;
    logic                  hrdy;
    logic [4:0]            ev = 5'h00;
    logic                  irq = 1'b0;
    logic                  wpin = 1'b1;
    logic                  ill_p;
    logic                  imask_p;
    logic                  cpu_en;
    logic [5:0]            pwr;
    lpm_pkg::wake_src_type wsrc = '0;
    lpm_pkg::dbg_req_type  req;
    lpm_pkg::dbg_resp_type resp;
    lpm_pkg::mode_type     mode;
    int                    err_count = 0;
    int                    check_count = 0;
    int                    cyc = 0;
    int                    ill = 0;
    int                    imk = 0;
    logic [5:0]            cfg [5] = '{6'h03, 6'h0D, 6'h01, 6'h31, 6'h11};
    lpm_pkg::mode_type     md [5] = '{lpm_pkg::MODE_STOP3, lpm_pkg::MODE_STOP3,
        lpm_pkg::MODE_STOP3, lpm_pkg::MODE_STOP2, lpm_pkg::MODE_STOP1};

    low_power_mode_controller dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .hsel_i(htrans[1]), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
        .hresp_o(), .hrdata_o(hrdata), .wait_instr_i(ev[3]), .stop_instr_i(ev[4]),
        .enter_debug_instr_i(ev[0]), .debug_ctrl_break_i(ev[1]),
        .debug_unit_break_i(ev[2]), .force_debug_reset_i(1'b0), .irq_pending_i(irq),
        .wake_irq_i(wsrc), .dbg_req_i(req), .dbg_resp_o(resp),
        .debug_mode_select_pin_i(1'b1), .wake_pin_i(wpin), .reset_pin_n_i(1'b1),
        .supply_low_i(1'b0), .mode_o(mode), .cpu_clock_en_o(cpu_en),
        .bus_clock_en_o(pwr[5]), .debug_clock_en_o(pwr[4]), .regulator_full_o(pwr[3]),
        .core_reset_o(), .illegal_opcode_reset_o(ill_p), .reset_vector_fetch_o(),
        .irq_vector_take_o(), .clear_imask_o(imask_p), .pin_latch_o(pwr[2]),
        .pins_to_reset_o(pwr[1]), .wake_pin_input_mode_o(pwr[0]));
    debug_host_model host_u (.clk_i(clock_i), .resp_i(resp), .req_o(req));

    always #2.5 clock_i = ~clock_i;

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // cut a hang short; the full run needs a few hundred cycles
    always @(posedge clock_i) begin
        cyc++;
        if (ill_p === 1'b1) ill++;
        if (imask_p === 1'b1) imk++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock_i); while (hrdy !== 1'b1);
        r = hrdata;
    endtask

    task automatic want(input lpm_pkg::mode_type m);
        int n = 0;
        #1;
        while (mode !== m && n < 100) begin
            @(posedge clock_i);
            #1 n++;
        end
        chk("mode", 32'(m), 32'(mode));
    endtask

    task automatic fire(input int b);
        @(posedge clock_i);
        ev <= 5'(1 << b);
        @(posedge clock_i);
        ev <= 5'h00;
    endtask

    task automatic cmd(input lpm_pkg::dbg_cmd_type c, input logic [1:0] e);
        lpm_pkg::dbg_resp_type q;
        host_u.send(c, q);
        chk("dbg_resp", 32'(e), 32'(q));
    endtask

    initial begin
        repeat (5) @(posedge clock_i);
        reset_n_i <= 1'b1;
        want(lpm_pkg::MODE_RUN);
        bus(1'b0, `LPM_CTRL_OFS, 32'h0000_0000);
        chk("ctrl", 32'h0000_0000, r);
        bus(1'b0, 12'h008, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, r);
        for (int b = 0; b < 3; b++) begin
            fire(b);
            want(lpm_pkg::MODE_DEBUG);
            cmd(lpm_pkg::CMD_RESUME, 2'b10);
            want(lpm_pkg::MODE_RUN);
        end
        for (int c = 0; c < 7; c++) if (c != 3) cmd(lpm_pkg::dbg_cmd_type'(c), {c < 3, 1'b0});
        cmd(lpm_pkg::CMD_FORCE, 2'b10);
        for (int c = 0; c < 7; c++) cmd(lpm_pkg::dbg_cmd_type'(c), 2'b10);
        want(lpm_pkg::MODE_RUN);
        $display("debug command test done");
        fire(3);
        want(lpm_pkg::MODE_WAIT);
        chk("clocks", 32'h0000_0002, {pwr[5], cpu_en});
        cmd(lpm_pkg::CMD_MEM_STATUS, 2'b11);
        cmd(lpm_pkg::CMD_MEM, 2'b00);
        @(posedge clock_i);
        irq <= 1'b1;
        want(lpm_pkg::MODE_RUN);
        irq <= 1'b0;
        fire(3);
        cmd(lpm_pkg::CMD_FORCE, 2'b10);
        want(lpm_pkg::MODE_DEBUG);
        cmd(lpm_pkg::CMD_RESUME, 2'b10);
        chk("imask", 32'h0000_0002, 32'(imk));
        fire(4);
        want(lpm_pkg::MODE_RST);
        want(lpm_pkg::MODE_RUN);
        chk("illegal", 32'h0000_0001, 32'(ill));
        $display("wait and illegal stop test done");
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, `LPM_CTRL_OFS, 32'(cfg[i]));
            fire(4);
            want(md[i]);
            chk("power", 32'({1'b0, i == 0, i < 2, i == 3, i == 4, i > 2}), 32'(pwr));
            if (i == 0) begin
                cmd(lpm_pkg::CMD_MEM_STATUS, 2'b11);
                cmd(lpm_pkg::CMD_FORCE, 2'b10);
                cmd(lpm_pkg::CMD_CPU_REG, 2'b10);
                cmd(lpm_pkg::CMD_RESUME, 2'b10);
            end else begin
                @(posedge clock_i);
                if (i < 3) wsrc.key <= 1'b1;
                else wpin <= 1'b0;
            end
            want(lpm_pkg::MODE_RUN);
            wsrc <= '0;
            wpin <= 1'b1;
            bus(1'b0, `LPM_STAT_OFS, 32'h0000_0000);
            chk("flags", (i == 3) ? 32'h0000_0009 : (i == 4) ? 32'h0000_0002 : 32'h0, 32'(r[3:0]));
            bus(1'b0, `LPM_CTRL_OFS, 32'h0000_0000);
            chk("ctrl", (i > 2) ? 32'h0000_0000 : 32'(cfg[i]), 32'(r[5:0]));
            bus(1'b1, `LPM_STAT_OFS, 32'h0000_0004);
            bus(1'b0, `LPM_STAT_OFS, 32'h0000_0000);
            chk("ack", 32'h0000_0000, 32'(r[3:0]));
            $display("stop case %0d done", i);
        end
        summarize();
    end
endmodule
